// >>> bench/ptqbr_backend.sv
// local back-end model that feeds quadwords to the wide target
`timescale 1ns/1ns
`default_nettype none
module ptqbr_backend
  import ptqbr_pkg::*;
(
  input wire logic clk,
  input wire logic stall, // hold ready off for a while
  input wire logic [31:0] local_captured_address,
  input wire logic local_wide_transfer_flag,
  input wire logic [PTQBR_REGIONS-1:0] region_hit,
  input wire logic local_low_half_strobe_n,
  input wire logic local_high_half_strobe_n,
  output logic local_target_ready_n,
  output logic [PTQBR_DATA_W-1:0] local_data_in
);
  logic [7:0] idx; // quadword index within the burst
  logic [PTQBR_DATA_W-1:0] last; // value seen on the data bus last cycle
  logic [PTQBR_DATA_W-1:0] word; // quadword for the current index
  logic take; // both transfer strobes low

  //////////////////////////////////////////////////////////////////////////
  initial begin
    local_target_ready_n = 1'h1;
    idx = 8'h00;
    last = '0;
  end

  assign take = !local_low_half_strobe_n && !local_high_half_strobe_n;

  // data tag is the start address in the upper half and the index in the low byte; narrow bursts invert the upper half
  always_comb begin
    word = {local_captured_address, 24'h00_0000, idx};
    if (!local_wide_transfer_flag) begin
      word[63:32] = ~local_captured_address;
    end
  end

  // outside strobes the bus flips, so stale data never looks valid
  assign local_data_in = take ? word : ~last;

  //////////////////////////////////////////////////////////////////////////
  // ready follows the chip select one clock late, like a slow back-end
  always @(posedge clk) begin
    local_target_ready_n <= !((|region_hit) && !stall);
    last <= local_data_in;
    if (region_hit == '0) begin
      idx <= 8'h00;
    end else if (take) begin
      idx <= idx + 8'h01;
    end
  end
endmodule : ptqbr_backend
`default_nettype wire

// >>> bench/tb_top.sv
// bench: bus master stimulus and checks for the wide target read
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import ptqbr_pkg::*;
  // one row per ordinary burst
  typedef struct {
    logic [31:0] addr; // start address
    logic [3:0] cmd; // bus command
    logic wide; // wide request
    int n; // data phases, two at least
    int hk; // phase that gets the stalls, below n-1
    int ip; // master wait cycles
    int bs; // back-end stall cycles
    logic fast; // fast select timing
  } ptqbr_row_t;

  logic clk, rst_n, speed, framen, req64n, irdyn, stall;
  logic [63:0] ad_in, ad_out, ld;
  logic [7:0] cben;
  logic ad_oe, trdyn, devseln, ack64n, resp_oe, wflag;
  logic lo_n, hi_n, rdy_n, fsp;
  logic [31:0] caddr;
  logic [PTQBR_REGIONS-1:0] hit;
  int failures, checks_done;

  ptqbr_row_t rows [7] = '{
    '{PTQBR_REGION0_BASE + 32'h40, PTQBR_CMD_MEM_READ, 1, 3, 0, 0, 0, 0},
    '{PTQBR_REGION1_BASE + 32'h8, PTQBR_CMD_MEM_READ_MULT, 1, 5, 1, 2, 2, 0},
    '{PTQBR_REGION0_BASE + 32'hff8, PTQBR_CMD_MEM_READ_LINE, 0, 2, 0, 0, 0, 1},
    '{32'h3000_0000, PTQBR_CMD_MEM_READ, 1, 3, 0, 0, 0, 0},
    '{PTQBR_REGION0_BASE, 4'h7, 1, 3, 0, 0, 0, 0},
    '{PTQBR_REGION1_BASE + 32'h100, PTQBR_CMD_MEM_READ, 1, 4, 2, 20, 0, 0},
    '{PTQBR_REGION0_BASE + 32'h80, PTQBR_CMD_MEM_READ_MULT, 1, 4, 1, 0, 3, 0}
  };

  //////////////////////////////////////////////////////////////////////////
  ptqbr_target dut (.clk, .rst_n, .select_response_speed(speed), .framen,
    .req64n, .irdyn, .ad_in, .cben, .ad_out, .ad_oe, .trdyn_out(trdyn),
    .devseln_out(devseln), .ack64n_out(ack64n), .resp_oe,
    .local_captured_address(caddr), .local_wide_transfer_flag(wflag),
    .region_hit(hit), .local_target_ready_n(rdy_n),
    .local_low_half_strobe_n(lo_n), .local_high_half_strobe_n(hi_n),
    .local_data_in(ld), .fifo_space(fsp));

  ptqbr_backend backend (.clk, .stall, .local_captured_address(caddr),
    .local_wide_transfer_flag(wflag), .region_hit(hit),
    .local_low_half_strobe_n(lo_n), .local_high_half_strobe_n(hi_n),
    .local_target_ready_n(rdy_n), .local_data_in(ld));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      failures++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask : chk

  task automatic give_verdict();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict

  // all responses quiet, as after reset
  task automatic idle_chk();
    chk(hit === '0 && resp_oe === 1'b0 && ad_oe === 1'b0, "idle select");
    chk(lo_n === 1'b1 && hi_n === 1'b1 && trdyn === 1'b1, "idle strobes");
  endtask : idle_chk

  // one read burst; entered and left at a falling edge
  task automatic burst(input ptqbr_row_t r);
    logic [1:0] exph;
    logic [63:0] exp;
    int k, p, t;
    exph = '0;
    if (r.cmd inside {PTQBR_CMD_MEM_READ, PTQBR_CMD_MEM_READ_MULT,
                      PTQBR_CMD_MEM_READ_LINE}) begin
      exph[0] = (r.addr & PTQBR_REGION_MASK) == PTQBR_REGION0_BASE;
      exph[1] = (r.addr & PTQBR_REGION_MASK) == PTQBR_REGION1_BASE;
    end
    speed = !r.fast;
    framen = 1'b0;
    req64n = !r.wide;
    ad_in = {32'h0000_0000, r.addr};
    cben = {4'h0, r.cmd};
    @(negedge clk);
    chk(caddr === r.addr, "captured address");
    chk(wflag === r.wide, "wide flag");
    ad_in = ~ad_in;
    cben = 8'h00;
    irdyn = 1'b0;
    @(negedge clk);
    chk(hit === exph, "region select");
    if (exph == '0) begin
      // refused: nothing answers until the master gives up
      repeat (4) begin
        @(negedge clk);
        chk(hit === '0 && resp_oe === 1'b0, "miss answered");
      end
      framen = 1'b1;
      req64n = 1'b1;
      irdyn = 1'b1;
    end else begin
      @(negedge clk);
      chk(devseln === 1'b0 && ack64n === !r.wide, "select late");
      k = 0;
      p = 0;
      t = 0;
      while (k < r.n) begin
        ad_in = ~ad_in; // released lines keep moving
        irdyn = (k == r.hk) && (p < r.ip);
        stall = (k == r.hk) && (p < r.bs);
        if (k == r.hk) begin
          p++;
        end
        if (k == r.n - 1) begin
          framen = 1'b1;
          req64n = 1'b1;
        end
        if (t == 1) begin
          chk(lo_n === 1'b0 && hi_n === 1'b0, "strobes late");
        end
        if (t == 2) begin
          chk(trdyn === 1'b1, "ready too early");
        end
        if (trdyn === 1'b0 && irdyn === 1'b0) begin
          exp = {r.addr, 24'h00_0000, 8'(k)};
          chk(ad_oe === 1'b1, "ad not driven");
          if (r.wide) begin
            chk(ad_out === exp, "quadword");
          end else begin
            chk(ad_out[31:0] === exp[31:0], "low half");
          end
          k++;
        end
        @(negedge clk);
        t++;
        if (t > 80) begin
          failures++;
          $display("[ERR] %0t burst hung", $time);
          give_verdict();
        end
      end
      irdyn = 1'b1;
      cben = ~cben;
      chk(ad_oe === 1'b0 && trdyn === 1'b1, "ad held");
      chk(devseln === 1'b1 && ack64n === 1'b1, "select held");
      chk(hit === '0 && lo_n === 1'b1 && hi_n === 1'b1, "no finish");
      @(negedge clk);
      chk(resp_oe === 1'b0, "response lines held");
    end
    repeat (2) @(negedge clk);
  endtask : burst

  //////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    speed = 1'b1;
    framen = 1'b1;
    req64n = 1'b1;
    irdyn = 1'b1;
    stall = 1'b0;
    ad_in = '0;
    cben = '0;
    failures = 0;
    checks_done = 0;
    repeat (4) @(negedge clk);
    idle_chk();
    chk(fsp === 1'b1, "buffer not empty");
    rst_n = 1'b1;
    @(negedge clk);
    foreach (rows[i]) begin
      burst(rows[i]);
    end
    // reset in the middle of a selected burst
    framen = 1'b0;
    req64n = 1'b0;
    ad_in = {32'h0000_0000, PTQBR_REGION0_BASE};
    cben = {4'h0, PTQBR_CMD_MEM_READ};
    @(negedge clk);
    irdyn = 1'b0;
    cben = 8'h00;
    repeat (5) @(negedge clk);
    rst_n = 1'b0;
    framen = 1'b1;
    req64n = 1'b1;
    irdyn = 1'b1;
    repeat (2) @(negedge clk);
    idle_chk();
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    burst(rows[0]);
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire

// >>> hdl/ptqbr_fifo.sv
// show-ahead fifo with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module ptqbr_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [AW:0] count; // words held
  logic [AW:0] next_count;
  logic [AW-1:0] wptr; // write pointer
  logic [AW-1:0] next_wptr;
  logic [AW-1:0] rptr; // read pointer
  logic [AW-1:0] next_rptr;
  logic push;
  logic pop;
  logic [WIDTH-1:0] mem_q; // registered memory read
  logic bypass; // word written last cycle at read pointer
  logic [WIDTH-1:0] held; // copy of that word
  logic next_bypass;

  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  // memory read has one cycle latency, so a fresh word is forwarded
  assign out_data = bypass ? held : mem_q;

  ptqbr_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) u_mem (
    .clk(clk),
    .wr_en(push),
    .wr_addr(wptr),
    .wr_data(in_data),
    .rd_addr(next_rptr),
    .rd_data(mem_q)
  );

  // pointer and count next values
  always_comb begin
    next_wptr = wptr + AW'(push);
    next_rptr = rptr + AW'(pop);
    next_count = count + (AW+1)'(push) - (AW+1)'(pop);
    next_bypass = push && (wptr == next_rptr);
    if (flush) begin
      next_wptr = '0;
      next_rptr = '0;
      next_count = '0;
      next_bypass = 1'b0;
    end
  end

  // register pointer state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
      bypass <= 1'b0;
      held <= '0;
    end else begin
      wptr <= next_wptr;
      rptr <= next_rptr;
      count <= next_count;
      bypass <= next_bypass;
      held <= in_data;
    end
  end
endmodule : ptqbr_fifo
`default_nettype wire

// >>> hdl/ptqbr_mem.sv
// small dual port memory with registered read data
`timescale 1ns/1ns
`default_nettype none
module ptqbr_mem #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] store [DEPTH]; // storage array, no reset needed

  // write port and registered read port
  always_ff @(posedge clk) begin
    if (wr_en) begin
      store[wr_addr] <= wr_data;
    end
    rd_data <= store[rd_addr];
  end
endmodule : ptqbr_mem
`default_nettype wire

// >>> hdl/ptqbr_pkg.sv
// shared constants and types for the wide target burst read block
package ptqbr_pkg;
  localparam int PTQBR_DATA_W = 64; // quadword width
  localparam int PTQBR_BE_W = 8; // byte enable width
  localparam int PTQBR_REGIONS = 2; // number of address regions
  localparam int PTQBR_FIFO_DEPTH = 16; // read data buffer depth
  localparam int PTQBR_FIFO_AW = 4; // buffer pointer width
  localparam logic [3:0] PTQBR_CMD_MEM_READ = 4'h6; // memory read
  localparam logic [3:0] PTQBR_CMD_MEM_READ_MULT = 4'hc; // read multiple
  localparam logic [3:0] PTQBR_CMD_MEM_READ_LINE = 4'he; // read line
  localparam logic [31:0] PTQBR_REGION0_BASE = 32'h1000_0000; // region 0
  localparam logic [31:0] PTQBR_REGION1_BASE = 32'h2000_0000; // region 1
  localparam logic [31:0] PTQBR_REGION_MASK = 32'hfff0_0000; // 1 MiB each
  localparam logic PTQBR_SLOW_RESET = 1'h1; // select speed after reset
  // bus facing sequence
  typedef enum logic [2:0] {
    PTQBR_IDLE = 3'b000,
    PTQBR_DECODE = 3'b001,
    PTQBR_HIT = 3'b010,
    PTQBR_DATA = 3'b011,
    PTQBR_TURN = 3'b100,
    PTQBR_RELEASE = 3'b101,
    PTQBR_MISS = 3'b110
  } ptqbr_state_t;
endpackage : ptqbr_pkg

// >>> hdl/ptqbr_target.sv
// wide target burst read engine between bus and local back-end
`timescale 1ns/1ns
`default_nettype none
module ptqbr_target
  import ptqbr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic select_response_speed, // 1: slow select timing
  input wire logic framen,
  input wire logic req64n,
  input wire logic irdyn,
  input wire logic [PTQBR_DATA_W-1:0] ad_in,
  input wire logic [PTQBR_BE_W-1:0] cben,
  output logic [PTQBR_DATA_W-1:0] ad_out,
  output logic ad_oe,
  output logic trdyn_out,
  output logic devseln_out,
  output logic ack64n_out,
  output logic resp_oe, // drives trdyn, devseln, ack64n
  output logic [31:0] local_captured_address,
  output logic local_wide_transfer_flag,
  output logic [PTQBR_REGIONS-1:0] region_hit,
  input wire logic local_target_ready_n,
  output logic local_low_half_strobe_n,
  output logic local_high_half_strobe_n,
  input wire logic [PTQBR_DATA_W-1:0] local_data_in,
  output logic fifo_space // buffer can take another quadword
);
  ////////////////////////////////////////////////////////////////////////
  // state
  ptqbr_state_t state; // bus facing sequence
  ptqbr_state_t next_state;
  logic [31:0] addr_q; // captured address
  logic [31:0] next_addr_q;
  logic [3:0] cmd_q; // captured command
  logic [3:0] next_cmd_q;
  logic wide; // wide request seen
  logic next_wide;
  logic [PTQBR_REGIONS-1:0] hit; // region select
  logic [PTQBR_REGIONS-1:0] next_hit;
  logic rdy1; // ready seen last cycle
  logic rdy2; // ready seen two cycles back
  logic irdy1; // irdyn asserted last cycle
  logic trdy; // trdyn currently asserted
  logic next_trdy;
  logic sel; // devseln asserted, ack64n too when wide
  logic next_sel;
  logic oe; // response lines driven
  logic next_oe;
  logic adoe; // ad driven
  logic next_adoe;
  logic strobe; // transfer strobes asserted
  logic next_strobe;
  logic last; // frame seen released during data
  logic next_last;
  logic [PTQBR_DATA_W-1:0] ad_q; // quadword on ad
  logic [PTQBR_DATA_W-1:0] next_ad_q;
  logic have; // ad_q holds a quadword not yet taken by the master
  logic next_have;
  logic [PTQBR_FIFO_AW:0] fill; // words in the buffer
  logic [PTQBR_FIFO_AW:0] next_fill;
  // a strobe already in flight still needs a slot, so room looks ahead one
  logic room;

  // buffer links
  logic f_in_valid;
  logic f_in_ready;
  logic f_out_valid;
  logic f_out_ready;
  logic [PTQBR_DATA_W-1:0] f_out_data;
  logic f_flush;
  logic space_q;

  // region decode of the captured address
  logic [PTQBR_REGIONS-1:0] match;
  logic [31:0] base [PTQBR_REGIONS];
  logic cmd_ok;
  logic data_phase_done; // trdyn and irdyn both low this cycle

  assign base[0] = PTQBR_REGION0_BASE;
  assign base[1] = PTQBR_REGION1_BASE;
  genvar gi;
  generate
    for (gi = 0; gi < PTQBR_REGIONS; gi++) begin : g_region
      assign match[gi] = (addr_q & PTQBR_REGION_MASK) == base[gi];
    end
  endgenerate
  // only memory reads are answered here; writes live elsewhere
  assign cmd_ok = (cmd_q == PTQBR_CMD_MEM_READ) ||
                  (cmd_q == PTQBR_CMD_MEM_READ_MULT) ||
                  (cmd_q == PTQBR_CMD_MEM_READ_LINE);
  assign data_phase_done = trdy && !irdyn;
  assign room = (fill + (PTQBR_FIFO_AW+1)'(strobe)) <
                PTQBR_FIFO_DEPTH[PTQBR_FIFO_AW:0];

  ////////////////////////////////////////////////////////////////////////
  // strobes push local data into the buffer as it is handed over
  // back-end data comes with the strobes in the same cycle, captured while strobe set
  assign f_in_valid = strobe && state == PTQBR_DATA;
  // head moves into ad_q when it is empty or its word was just taken
  assign f_out_ready = f_out_valid && (!have || data_phase_done);
  assign f_flush = (state == PTQBR_RELEASE);

  ptqbr_fifo #(
    .WIDTH(PTQBR_DATA_W),
    .DEPTH(PTQBR_FIFO_DEPTH),
    .AW(PTQBR_FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .flush(f_flush),
    .in_valid(f_in_valid),
    .in_ready(f_in_ready),
    .in_data(local_data_in),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out_data)
  );

  ////////////////////////////////////////////////////////////////////////
  // next state of the whole sequence
  always_comb begin
    next_state = state;
    next_addr_q = addr_q;
    next_cmd_q = cmd_q;
    next_wide = wide;
    next_hit = hit;
    next_trdy = trdy;
    next_sel = sel;
    next_oe = oe;
    next_adoe = adoe;
    next_strobe = 1'b0;
    next_last = last;
    next_ad_q = ad_q;
    next_have = have;
    next_fill = fill + (PTQBR_FIFO_AW+1)'(f_in_valid && f_in_ready) -
                (PTQBR_FIFO_AW+1)'(f_out_ready);
    case (state)
      PTQBR_IDLE: begin
        // address phase: capture address, command and wide request
        if (!framen) begin
          next_addr_q = ad_in[31:0];
          next_cmd_q = cben[3:0];
          next_wide = !req64n;
          next_last = 1'b0;
          next_state = PTQBR_DECODE;
        end
      end
      PTQBR_DECODE: begin
        // region select shows up in the third clock
        if (cmd_ok && match != '0) begin
          next_hit = match;
          next_state = PTQBR_HIT;
        end else begin
          next_state = PTQBR_MISS;
        end
      end
      PTQBR_HIT: begin
        // both timings leave here after one clock, since sel is still clear on entry
        if (select_response_speed || !sel) begin
          next_sel = 1'b1;
          next_oe = 1'b1;
          next_adoe = 1'b1;
          next_state = PTQBR_DATA;
        end
      end
      PTQBR_DATA: begin
        // strobes one cycle after ready; held while ready, room and frame not released
        next_strobe = !local_target_ready_n && room && !last;
        if (f_out_ready) begin
          next_ad_q = f_out_data;
          next_have = 1'b1;
        end else if (data_phase_done) begin
          next_have = 1'b0;
        end
        // two cycles of ready lets the quadword go out
        next_trdy = rdy1 && rdy2 && next_have;
        if (framen) begin
          next_last = 1'b1;
        end
        // final phase done once frame was released and data moved
        if (data_phase_done && framen) begin
          next_trdy = 1'b0;
          next_sel = 1'b0;
          next_adoe = 1'b0;
          next_hit = '0;
          next_strobe = 1'b0;
          next_have = 1'b0;
          next_state = PTQBR_TURN;
        end
      end
      PTQBR_TURN: begin
        // lines are deasserted, now released for the next owner
        next_oe = 1'b0;
        next_state = PTQBR_RELEASE;
      end
      PTQBR_RELEASE: begin
        next_wide = 1'b0;
        next_fill = '0; // buffer is flushed here
        next_state = PTQBR_IDLE;
      end
      PTQBR_MISS: begin
        // stay silent until the master ends the attempt
        if (framen && irdyn) begin
          next_state = PTQBR_IDLE;
        end
      end
      default: begin
        next_state = PTQBR_IDLE;
      end
    endcase
  end

  // register the sequence
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= PTQBR_IDLE;
      addr_q <= '0;
      cmd_q <= '0;
      wide <= 1'b0;
      hit <= '0;
      trdy <= 1'b0;
      sel <= 1'b0;
      oe <= 1'b0;
      adoe <= 1'b0;
      strobe <= 1'b0;
      last <= 1'b0;
      ad_q <= '0;
      rdy1 <= 1'b0;
      rdy2 <= 1'b0;
      irdy1 <= 1'b0;
      space_q <= 1'b1; // buffer is empty after reset
      have <= 1'b0;
      fill <= '0;
    end else begin
      state <= next_state;
      addr_q <= next_addr_q;
      cmd_q <= next_cmd_q;
      wide <= next_wide;
      hit <= next_hit;
      trdy <= next_trdy;
      sel <= next_sel;
      oe <= next_oe;
      adoe <= next_adoe;
      strobe <= next_strobe;
      last <= next_last;
      ad_q <= next_ad_q;
      rdy1 <= !local_target_ready_n;
      rdy2 <= rdy1;
      irdy1 <= !irdyn;
      space_q <= f_in_ready;
      have <= next_have;
      fill <= next_fill;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs from flip-flops, inverted where active low; ack64n_out gates sel with wide
  assign ad_out = ad_q;
  assign ad_oe = adoe;
  assign trdyn_out = !trdy;
  assign devseln_out = !sel;
  assign ack64n_out = !(sel && wide);
  assign resp_oe = oe;
  assign local_captured_address = addr_q;
  assign local_wide_transfer_flag = wide;
  assign region_hit = hit;
  assign local_low_half_strobe_n = !strobe;
  assign local_high_half_strobe_n = !strobe;
  assign fifo_space = space_q;

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_hit_rise;
    $rose(region_hit != '0);
  endsequence

  a_decode_to_hit: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(framen) && state == PTQBR_IDLE
    |-> ##1 (state == PTQBR_DECODE)
    ##1 (state == PTQBR_HIT || state == PTQBR_MISS))
    else $error("decode did not settle two clocks after address");
  a_slow_select: assert property (@(posedge clk) disable iff (!rst_n)
    s_hit_rise ##0 select_response_speed |=> !devseln_out)
    else $error("select not asserted the clock after region hit");
  a_strobe_follow: assert property (@(posedge clk) disable iff (!rst_n)
    state == PTQBR_DATA && !local_target_ready_n && room && !last
    && !(trdy && !irdyn && framen) |=> !local_low_half_strobe_n)
    else $error("strobe missing after local ready");
  a_trdy_needs_rdy: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(trdyn_out) |-> $past(rdy1) && $past(rdy2))
    else $error("trdyn asserted without two cycles of ready");
  a_turn_release: assert property (@(posedge clk) disable iff (!rst_n)
    state == PTQBR_DATA && trdy && !irdyn && framen
    |=> !ad_oe && devseln_out && trdyn_out && region_hit == '0)
    else $error("turnaround did not release data lines");
  a_turn_strobes: assert property (@(posedge clk) disable iff (!rst_n)
    state == PTQBR_TURN |-> local_low_half_strobe_n
    && local_high_half_strobe_n)
    else $error("strobes still set in turnaround");
  a_idle_release: assert property (@(posedge clk) disable iff (!rst_n)
    state == PTQBR_TURN |=> !resp_oe)
    else $error("response lines still driven after turnaround");
  a_miss_silent: assert property (@(posedge clk) disable iff (!rst_n)
    state == PTQBR_MISS |-> devseln_out && trdyn_out && region_hit == '0)
    else $error("response during unmatched transaction");
  a_wide_flag: assert property (@(posedge clk) disable iff (!rst_n)
    state == PTQBR_IDLE && !framen
    |=> local_wide_transfer_flag == $past(!req64n))
    else $error("wide flag does not follow request");
endmodule : ptqbr_target
`default_nettype wire
